// file: rtl/ccba_core.sv
// Function
// - register address is 0, then 1 at bit 8, bank pointer, low opcode bits.
// - eight 8-bit registers per bank, sixteen banks usable, bank chosen by pointer.
// - half-carry set on carry or borrow between bit 3 and bit 4.
// - interrupt enable flag gates interrupts; reset clears it.
// - request accepted only if its level is strictly above the held level.
// - level field 00 highest, 11 lowest; 11 blocks every request.
// - negative flag follows result bit 7.
// - zero flag set for all-zero result, cleared otherwise.
// - overflow flag follows two's complement overflow.
// - carry flag set on carry out of or borrow into bit 7.
// - shifts load carry with the bit shifted out.
// - status word holds bank pointer in upper byte, flags in lower byte.
// - reset sets level field to 11 and clears interrupt enable.
// - 8-bit operations use only low bytes of accumulator and temporary.
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module ccba_core
  import ccba_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // alu operation
  input wire logic op_valid_i,
  input wire ccba_op_t op_kind_i,
  input wire logic [15:0] acc_i,
  input wire logic [15:0] tmp_i,
  input wire logic [4:0] flag_we_i,
  input wire logic [7:0] opcode_i,
  // interrupt request
  input wire logic irq_req_i,
  input wire logic [1:0] irq_level_i,
  // results
  output logic [7:0] result_o,
  output logic [15:0] psw_o,
  output logic [15:0] gpr_addr_o,
  output logic bank_ok_o,
  output logic irq_accept_o
);
  // ----------------------------------------
  // flag computation
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] res;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } ccba_alu_t;

  function automatic ccba_alu_t ccba_alu(input ccba_op_t k, input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    ccba_alu_t o;
    logic [8:0] full;
    logic [4:0] half;
    logic sub;
    logic ci;
    o = '0;
    sub = (k == CCBA_OP_SUB) || (k == CCBA_OP_SUBC);
    ci = ((k == CCBA_OP_ADDC) || (k == CCBA_OP_SUBC)) ? cin : 1'b0;
    full = 9'h000;
    half = 5'h00;
    case (k)
      CCBA_OP_ADD, CCBA_OP_ADDC: begin
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      end
      CCBA_OP_SUB, CCBA_OP_SUBC: begin
        full = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      end
      CCBA_OP_SHL: begin
        full = {a, cin};
      end
      CCBA_OP_SHR: begin
        full = {a[0], cin, a[7:1]};
      end
      default: begin
        full = {1'b0, a};
      end
    endcase
    o.res = full[7:0];
    o.c = full[8];
    o.h = half[4];
    o.n = full[7];
    o.z = (full[7:0] == 8'h00);
    if (sub) begin
      o.v = (a[7] != b[7]) && (full[7] != a[7]);
    end else if ((k == CCBA_OP_ADD) || (k == CCBA_OP_ADDC)) begin
      o.v = (a[7] == b[7]) && (full[7] != a[7]);
    end else begin
      o.v = 1'b0;
    end
    return o;
  endfunction : ccba_alu

  // ----------------------------------------
  // status word and datapath state
  // ----------------------------------------
  logic [15:0] psw_reg;
  logic [15:0] psw_next;
  logic [7:0] res_reg;
  logic [7:0] res_next;
  logic irq_reg;
  logic irq_next;
  ccba_alu_t alu;
  logic bus_wr;

  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (wb_adr_i == CCBA_OFS_PSW);

  always_comb begin
    alu = ccba_alu(op_kind_i, acc_i[7:0], tmp_i[7:0], psw_reg[CCBA_C_BIT]);
    psw_next = psw_reg;
    res_next = res_reg;
    if (bus_wr) begin
      if (wb_sel_i[0]) begin
        psw_next[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        psw_next[15:8] = wb_dat_i[15:8] & CCBA_PSW_MASK[15:8];
      end
    end
    // a flag update from the alu lands after the bus write so it is not lost
    if (op_valid_i) begin
      res_next = alu.res;
      if (flag_we_i[CCBA_WE_H]) begin
        psw_next[CCBA_H_BIT] = alu.h;
      end
      if (flag_we_i[CCBA_WE_N]) begin
        psw_next[CCBA_N_BIT] = alu.n;
      end
      if (flag_we_i[CCBA_WE_Z]) begin
        psw_next[CCBA_Z_BIT] = alu.z;
      end
      if (flag_we_i[CCBA_WE_V]) begin
        psw_next[CCBA_V_BIT] = alu.v;
      end
      if (flag_we_i[CCBA_WE_C]) begin
        psw_next[CCBA_C_BIT] = alu.c;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_reg <= CCBA_PSW_RESET;
      res_reg <= 8'h00;
    end else begin
      psw_reg <= psw_next;
      res_reg <= res_next;
    end
  end

  // ----------------------------------------
  // interrupt acceptance
  // ----------------------------------------
  logic [1:0] il_cur;
  assign il_cur = psw_reg[CCBA_IL_LSB +: 2];

  always_comb begin
    irq_next = irq_req_i && psw_reg[CCBA_I_BIT]
               && (il_cur != CCBA_IL_BLOCK)
               && (irq_level_i < il_cur);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // register bank address
  // ----------------------------------------
  ccba_gpr_addr u_gpr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bank_ptr_i(psw_reg[CCBA_RP_LSB +: CCBA_RP_W]),
    .opcode_i(opcode_i),
    .gpr_addr_o(gpr_addr_o),
    .bank_ok_o(bank_ok_o)
  );

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  logic ack_reg;
  logic ack_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rd_next = rd_reg;
    if (ack_next && !wb_we_i) begin
      case (wb_adr_i)
        CCBA_OFS_PSW: rd_next = {16'h0000, psw_reg};
        CCBA_OFS_GPR: rd_next = {15'h0000, bank_ok_o, gpr_addr_o};
        CCBA_OFS_STAT: rd_next = {23'h00_0000, irq_reg, res_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rd_reg <= rd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign result_o = res_reg;
  assign psw_o = psw_reg;
  assign irq_accept_o = irq_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RESET_IL: assert property (@(posedge clk_i) disable iff (rst_i) $past(rst_i) |->
    psw_o[CCBA_IL_LSB +: 2] == 2'b11 && !psw_o[CCBA_I_BIT])
    else $error("reset did not set level field and clear enable");
  AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_accept_o |-> $past(psw_reg[CCBA_I_BIT]) && $past(irq_req_i))
    else $error("interrupt accepted while disabled");
  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_accept_o |-> $past(irq_level_i) < $past(il_cur))
    else $error("interrupt accepted at too low a level");
  AST_IL_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (il_cur == 2'b11) |=> !irq_accept_o)
    else $error("level 11 did not block");
  AST_IRQ_TAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_req_i && psw_reg[CCBA_I_BIT] && il_cur == 2'b10 && irq_level_i == 2'b00) |=> irq_accept_o)
    else $error("valid request not accepted");
  AST_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_valid_i && flag_we_i[CCBA_WE_Z]) |=> psw_o[CCBA_Z_BIT] == (result_o == 8'h00))
    else $error("zero flag wrong");
  AST_NEG: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_valid_i && flag_we_i[CCBA_WE_N]) |=> psw_o[CCBA_N_BIT] == result_o[7])
    else $error("negative flag wrong");
  AST_SHL_C: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_valid_i && op_kind_i == CCBA_OP_SHL && flag_we_i[CCBA_WE_C]) |=> psw_o[CCBA_C_BIT] == $past(acc_i[7]))
    else $error("shift carry wrong");
  AST_ADD_C: assert property (@(posedge clk_i) disable iff (rst_i)
    (op_valid_i && op_kind_i == CCBA_OP_ADD && flag_we_i[CCBA_WE_C]) |=>
    psw_o[CCBA_C_BIT] == ({1'b0, $past(acc_i[7:0])} + {1'b0, $past(tmp_i[7:0])} > 9'h0FF))
    else $error("add carry wrong");
  AST_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!bus_wr && !(op_valid_i && flag_we_i[CCBA_WE_V])) |=> $stable(psw_o[CCBA_V_BIT]))
    else $error("overflow flag changed without update");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : ccba_core

// file: rtl/ccba_gpr_addr.sv
`timescale 1ns/1ps
module ccba_gpr_addr
  import ccba_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // operand source
  input wire logic [4:0] bank_ptr_i,
  input wire logic [7:0] opcode_i,
  // generated address
  output logic [15:0] gpr_addr_o,
  output logic bank_ok_o
);
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic ok_reg;
  logic ok_next;

  always_comb begin
    addr_next = {CCBA_GPR_HIGH_ZERO, CCBA_GPR_AREA_BIT, bank_ptr_i, opcode_i[2:0]};
    ok_next = (bank_ptr_i < CCBA_BANKS_USABLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg <= 16'h0100;
      ok_reg <= 1'b1;
    end else begin
      addr_reg <= addr_next;
      ok_reg <= ok_next;
    end
  end

  assign gpr_addr_o = addr_reg;
  assign bank_ok_o = ok_reg;

  AST_GPR_MAP: assert property (@(posedge clk_i) disable iff (rst_i)
    gpr_addr_o == {7'h00, 1'b1, $past(bank_ptr_i), $past(opcode_i[2:0])})
    else $error("register bank address mismatch");
endmodule : ccba_gpr_addr

// file: rtl/ccba_pkg.sv
package ccba_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] CCBA_OFS_PSW = 4'h0;
  localparam logic [3:0] CCBA_OFS_GPR = 4'h4;
  localparam logic [3:0] CCBA_OFS_STAT = 4'h8;

  // ----------------------------------------
  // status word layout
  // ----------------------------------------
  localparam int CCBA_RP_LSB = 11;
  localparam int CCBA_RP_W = 5;
  localparam int CCBA_H_BIT = 7;
  localparam int CCBA_I_BIT = 6;
  localparam int CCBA_IL_LSB = 4;
  localparam int CCBA_N_BIT = 3;
  localparam int CCBA_Z_BIT = 2;
  localparam int CCBA_V_BIT = 1;
  localparam int CCBA_C_BIT = 0;
  localparam logic [15:0] CCBA_PSW_MASK = 16'hF8FF;
  localparam logic [15:0] CCBA_PSW_RESET = 16'h0030;
  localparam logic [1:0] CCBA_IL_BLOCK = 2'h3;

  // ----------------------------------------
  // register bank address layout
  // ----------------------------------------
  localparam logic [6:0] CCBA_GPR_HIGH_ZERO = 7'h00;
  localparam logic CCBA_GPR_AREA_BIT = 1'b1;
  localparam logic [4:0] CCBA_BANKS_USABLE = 5'h10;

  // ----------------------------------------
  // flag write-enable vector positions
  // ----------------------------------------
  localparam int CCBA_WE_C = 0;
  localparam int CCBA_WE_V = 1;
  localparam int CCBA_WE_Z = 2;
  localparam int CCBA_WE_N = 3;
  localparam int CCBA_WE_H = 4;

  typedef enum logic [2:0] {
    CCBA_OP_ADD,
    CCBA_OP_ADDC,
    CCBA_OP_SUB,
    CCBA_OP_SUBC,
    CCBA_OP_SHL,
    CCBA_OP_SHR,
    CCBA_OP_MOVE
  } ccba_op_t;
endpackage : ccba_pkg

// file: tb/ccba_cpu_model.sv
`timescale 1ns/1ps
module ccba_cpu_model
  import ccba_pkg::*;
(
  // clock
  input wire logic clk_i,
  // alu operation
  output logic op_valid_o,
  output ccba_op_t op_kind_o,
  output logic [15:0] acc_o,
  output logic [15:0] tmp_o,
  output logic [4:0] flag_we_o,
  output logic [7:0] opcode_o,
  // interrupt request
  output logic irq_req_o,
  output logic [1:0] irq_level_o
);
  initial begin
    op_valid_o = 1'b0;
    op_kind_o = CCBA_OP_MOVE;
    acc_o = 16'h0000;
    tmp_o = 16'h0000;
    flag_we_o = 5'h00;
    opcode_o = 8'h00;
    irq_req_o = 1'b0;
    irq_level_o = 2'h0;
  end

  // one op per call, valid for exactly one edge
  task automatic issue(input ccba_op_t k, input logic [15:0] a, input logic [15:0] t, input logic [4:0] we);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_kind_o <= k;
    acc_o <= a;
    tmp_o <= t;
    flag_we_o <= we;
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    // operands turn over once taken, so a late sample shows up
    acc_o <= ~a;
    tmp_o <= ~t;
  endtask : issue

  task automatic request(input logic r, input logic [1:0] l, input logic [7:0] opc);
    @(posedge clk_i);
    irq_req_o <= r;
    irq_level_o <= l;
    opcode_o <= opc;
    @(posedge clk_i);
  endtask : request
endmodule : ccba_cpu_model

// file: tb/tb_ccba_core.sv
`timescale 1ns/1ps
module tb_ccba_core
  import ccba_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'hF;
  logic [3:0] sel_pick = 4'hF;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic op_valid;
  ccba_op_t op_kind;
  logic [15:0] acc;
  logic [15:0] tmp;
  logic [4:0] flag_we;
  logic [7:0] opcode;
  logic irq_req;
  logic [1:0] irq_level;
  logic [7:0] result;
  logic [15:0] psw;
  logic [15:0] gpr_addr;
  logic bank_ok;
  logic irq_accept;
  int failures = 0;
  int check_count = 0;
  logic [15:0] psw_m;
  logic [31:0] q;

  always #25 clk_i = ~clk_i;

  ccba_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .op_valid_i(op_valid), .op_kind_i(op_kind), .acc_i(acc), .tmp_i(tmp), .flag_we_i(flag_we),
    .opcode_i(opcode), .irq_req_i(irq_req), .irq_level_i(irq_level), .result_o(result), .psw_o(psw),
    .gpr_addr_o(gpr_addr), .bank_ok_o(bank_ok), .irq_accept_o(irq_accept));

  ccba_cpu_model seq (.clk_i(clk_i), .op_valid_o(op_valid), .op_kind_o(op_kind), .acc_o(acc), .tmp_o(tmp),
    .flag_we_o(flag_we), .opcode_o(opcode), .irq_req_o(irq_req), .irq_level_o(irq_level));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_flag

  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel_pick;
    wb_wdat <= d;
    // no local limit: a missing ack is caught by the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (we && adr == CCBA_OFS_PSW) begin
      if (sel_pick[0]) begin
        psw_m[7:0] = d[7:0];
      end
      if (sel_pick[1]) begin
        psw_m[15:8] = d[15:8] & CCBA_PSW_MASK[15:8];
      end
    end
  endtask : wb_xfer

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // reference alu on low bytes only: {h, n, z, v, c, result}
  function automatic logic [12:0] alu_ref(input int k, input int a, input int t, input int c);
    int r;
    int h;
    int cy;
    int v;
    h = 0;
    v = 0;
    cy = c;
    if (k <= 1) begin
      r = a + t + ((k == 1) ? c : 0);
      h = ((a % 16) + (t % 16) + ((k == 1) ? c : 0)) > 15;
      cy = r > 255;
      v = ((a ^ r) & (t ^ r) & 128) != 0;
    end else if (k <= 3) begin
      r = a - t - ((k == 3) ? c : 0);
      h = ((a % 16) - (t % 16) - ((k == 3) ? c : 0)) < 0;
      cy = r < 0;
      v = ((a ^ t) & (a ^ r) & 128) != 0;
    end else if (k == 4) begin
      r = a * 2 + c;
      cy = a / 128;
    end else if (k == 5) begin
      r = a / 2 + c * 128;
      cy = a % 2;
    end else begin
      r = a;
    end
    r = r & 255;
    return {h[0], r >= 128, r == 0, v[0], cy[0], r[7:0]};
  endfunction : alu_ref

  initial begin
    #(50 * 40000);
    failures++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int k;
    logic [15:0] a;
    logic [15:0] t;
    logic [4:0] we;
    logic [12:0] e;
    logic x;
    void'($urandom(32'h237b));
    psw_m = CCBA_PSW_RESET;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk_val(psw, 16'h0030);
    chk_val(gpr_addr, 16'h0100);
    wb_xfer(1'b0, 4'hC, 32'h0000_0000);
    chk_val(q, 32'h0000_0000);
    // every bank pointer value, sixteen usable
    for (int b = 0; b < 32; b++) begin
      wb_xfer(1'b1, CCBA_OFS_PSW, {16'h0000, b[4:0], 3'h7, 8'($urandom)});
      seq.request(1'b0, 2'h0, 8'($urandom));
      #1;
      chk_val(gpr_addr, {7'h00, 1'b1, b[4:0], opcode[2:0]});
      chk_flag(bank_ok, b < 16);
      chk_val(psw, psw_m);
      wb_xfer(1'b0, CCBA_OFS_GPR, 32'h0000_0000);
      chk_val(q, {15'h0000, b < 16, 7'h00, 1'b1, b[4:0], opcode[2:0]});
    end
    // byte lanes reach one half of the status word each
    sel_pick = 4'h2;
    wb_xfer(1'b1, CCBA_OFS_PSW, $urandom);
    chk_val(psw, psw_m);
    sel_pick = 4'h1;
    wb_xfer(1'b1, CCBA_OFS_PSW, $urandom);
    chk_val(psw, psw_m);
    sel_pick = 4'hF;
    // random alu traffic with random flag enables
    for (int i = 0; i < 300; i++) begin
      k = $urandom_range(0, 6);
      a = 16'($urandom);
      t = 16'($urandom);
      we = 5'($urandom);
      we = (k == 6) ? we & 5'h1E : we;
      e = alu_ref(k, a[7:0], t[7:0], psw_m[CCBA_C_BIT]);
      seq.issue(ccba_op_t'(k), a, t, we);
      #1;
      if (we[CCBA_WE_C]) psw_m[CCBA_C_BIT] = e[8];
      if (we[CCBA_WE_V]) psw_m[CCBA_V_BIT] = e[9];
      if (we[CCBA_WE_Z]) psw_m[CCBA_Z_BIT] = e[10];
      if (we[CCBA_WE_N]) psw_m[CCBA_N_BIT] = e[11];
      if (we[CCBA_WE_H]) psw_m[CCBA_H_BIT] = e[12];
      chk_val(result, e[7:0]);
      chk_val(psw, psw_m);
    end
    // every enable, held level and request level
    for (int j = 0; j < 64; j++) begin
      wb_xfer(1'b1, CCBA_OFS_PSW, {16'h0000, 8'($urandom), 1'b0, j[5], j[4:3], 4'($urandom)});
      seq.request(j[0], j[2:1], 8'($urandom));
      #1;
      x = j[0] && j[5] && j[4:3] != 2'h3 && j[2:1] < j[4:3];
      chk_flag(irq_accept, x);
      wb_xfer(1'b0, CCBA_OFS_STAT, 32'h0000_0000);
      chk_val(q, {23'h00_0000, x, e[7:0]});
    end
    wb_xfer(1'b0, CCBA_OFS_PSW, 32'h0000_0000);
    chk_val(q, {16'h0000, psw_m});
    close_out();
  end
endmodule : tb_ccba_core
